// [freq_gen_divider.sv]
`timescale 1ns/1ps
`default_nettype none
`include "glue_io_consts.svh"

module freq_gen_divider
    import glue_io_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic                    clkEn,
    input  wire logic                    stageOneSel,
    input  wire logic                    secondStageSel,
    input  wire glue_io_pkg::final_code_t finalDividerCode,
    output logic                         freqOut
);
    logic [11:0] preCntQ;
    logic [11:0] preLimit;
    logic [6:0]  finCntQ;
    logic [6:0]  finHalf;
    logic        genOff;
    logic        preTick;

    // ====================
    // ratio decode: first two stages merge into one prescaler
    always_comb
    begin
        logic [11:0] s1;
        logic [11:0] s2;
        logic [23:0] prod;
        s1 = stageOneSel ? `GLUE_STAGE1_HIGH : `GLUE_STAGE1_LOW; // [R5] [R9]
        s2 = secondStageSel ? `GLUE_STAGE2_HIGH : `GLUE_STAGE2_LOW; // [R6] [R9]
        prod = s1 * s2;
        preLimit = prod[11:0];
        // final ratio 2^(code+1), toggling every half of it
        finHalf = 7'h01 << finalDividerCode; // [R7] [R10]
        genOff = (finalDividerCode == `GLUE_FINAL_OFF); // [R7] [R10]
        // >= keeps a shrinking ratio from running the counter away
        preTick = (preCntQ >= preLimit - 12'h001);
    end

    // ====================
    // prescaler; overall ratio 320 up to 245760
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || (clkEn && genOff))
            preCntQ <= 12'h000;
        else if (clkEn)
            preCntQ <= preTick ? 12'h000 : preCntQ + 12'h001; // [R1]
    end

    // ====================
    // final stage and square output; held low while off
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || (clkEn && genOff))
        begin
            finCntQ <= 7'h00;
            freqOut <= 1'b0; // [R20]
        end
        else if (clkEn && preTick)
        begin
            if (finCntQ >= finHalf - 7'h01)
            begin
                finCntQ <= 7'h00;
                freqOut <= ~freqOut; // [R20]
            end
            else
                finCntQ <= finCntQ + 7'h01;
        end
    end
endmodule
`default_nettype wire

// [glue_io_and_freq_gen.sv]
`timescale 1ns/1ps
`default_nettype none
`include "glue_io_consts.svh"

module glue_io_and_freq_gen
    import glue_io_pkg::*;
#(
    parameter int ADR_WIDTH = 8
)
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 clkEn,
    // wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [ADR_WIDTH-1:0] wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // pins
    output logic                      generalOutputBit,
    output logic                      freqOrDoneSharedPin,
    output logic                      freqGenZeroOut,
    input  wire logic                 generalInputOne,
    input  wire logic                 receiveOrInputTwoPin,
    input  wire logic                 edgeInterruptInput,
    // core side, same clock
    input  wire logic                 dmaDoneStrobeN,
    output logic                      serialReceiveData,
    input  wire logic                 globalMaskableIntEnable,
    input  wire logic                 edgeIntAck,
    output logic                      edgeIntReq,
    output glue_io_pkg::vector_low_t  edgeIntVectorLow
);
    import glue_io_pkg::*;

    // ====================
    // declarations
    logic [2:0]     pinRaw;
    logic [2:0]     syncStage1Q;
    logic [2:0]     syncQ;
    logic           inOneSync;
    logic           inTwoSync;
    logic           edgeInSync;
    logic           edgeInPrevQ;

    logic           outBitQ;
    logic           transferEndSelQ;
    logic           gen0StageOneQ;
    logic           gen0SecondQ;
    final_code_t    gen0FinalQ;
    logic           gen1StageOneQ;
    logic           gen1SecondQ;
    final_code_t    gen1FinalQ;
    logic           edgeIntEnableQ;
    logic           edgeStatusQ;
    logic           receiveFuncSelQ;
    logic           edgePendingQ;

    logic           gen0Out;
    logic           gen1Out;
    logic           sharedPinQ;
    logic           serialRxQ;

    logic           busReq;
    logic           busStart;
    logic           addrHit;
    reg_index_t     regIndex;
    logic           wrLow;
    reg_byte_t      wrByte;
    reg_byte_t      readByte;
    logic           rdEdgeCtrl;
    logic           risingEdge;

    // ====================
    // input synchronisers, one pair of flops per pin
    assign pinRaw = {edgeInterruptInput, receiveOrInputTwoPin, generalInputOne};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            // first flop feeds only the second one
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    syncStage1Q[gi] <= 1'b0;
                    syncQ[gi]       <= 1'b0;
                end
                else if (clkEn)
                begin
                    syncStage1Q[gi] <= pinRaw[gi]; // [R19]
                    syncQ[gi]       <= syncStage1Q[gi]; // [R19]
                end
            end
        end
    endgenerate

    assign inOneSync  = syncQ[0];
    assign inTwoSync  = syncQ[1];
    assign edgeInSync = syncQ[2];

    // ====================
    // bus decode: index in adr[4:2], only aligned words within range
    always_comb
    begin
        regIndex = wb_adr_i[4:2];
        addrHit  = (wb_adr_i[1:0] == 2'b00)
                && (wb_adr_i[ADR_WIDTH-1:5] == '0)
                && (regIndex <= `GLUE_IDX_RECEIVE_PIN_SELECT);
    end

    assign busReq   = wb_cyc_i && wb_stb_i;
    // one access per request; ack drops the cycle after it rose
    assign busStart = busReq && !wb_ack_o;
    // registers sit in the low byte lane
    assign wrLow    = busStart && wb_we_i && addrHit && wb_sel_i[0];
    assign wrByte   = wb_dat_i[7:0];
    assign rdEdgeCtrl = busStart && !wb_we_i && addrHit
                     && (regIndex == `GLUE_IDX_EDGE_INTERRUPT_CTRL);

    // ====================
    // read mux; undefined bits answer zero
    always_comb
    begin
        readByte = 8'h00; // [R14]
        case (regIndex)
            `GLUE_IDX_OUTPUT_PORT_CTRL:
                readByte[`GLUE_BIT_GENERAL_OUTPUT] = outBitQ;
            `GLUE_IDX_PIN_ROUTE_CTRL:
                readByte[`GLUE_BIT_TRANSFER_END_SEL] = transferEndSelQ;
            `GLUE_IDX_FREQ_GEN0_AND_INPUT_ONE:
            begin
                // read shows the pin, not the written stage-one bit
                readByte[`GLUE_BIT_STAGE_ONE]    = inOneSync; // [R4]
                readByte[`GLUE_BIT_SECOND_STAGE] = gen0SecondQ;
                readByte[`GLUE_LSB_FINAL_DIVIDER +: 3] = gen0FinalQ;
            end
            `GLUE_IDX_FREQ_GEN1_AND_INPUT_TWO:
            begin
                // pin reads zero while it serves the serial unit
                readByte[`GLUE_BIT_STAGE_ONE]    = inTwoSync && receiveFuncSelQ; // [R8]
                readByte[`GLUE_BIT_SECOND_STAGE] = gen1SecondQ;
                readByte[`GLUE_LSB_FINAL_DIVIDER +: 3] = gen1FinalQ;
            end
            `GLUE_IDX_EDGE_INTERRUPT_CTRL:
            begin
                readByte[`GLUE_BIT_EDGE_INT_ENABLE] = edgeIntEnableQ;
                readByte[`GLUE_BIT_EDGE_STATUS]     = edgeStatusQ;
            end
            `GLUE_IDX_RECEIVE_PIN_SELECT:
                readByte[`GLUE_BIT_RECEIVE_FUNC_SEL] = receiveFuncSelQ;
            default:
                readByte = 8'h00;
        endcase
    end

    // ====================
    // bus answer: ack one cycle after the request, unmapped reads zero
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            wb_ack_o <= busStart;
            if (busStart)
                wb_dat_o <= (addrHit && !wb_we_i) ? {24'h00_0000, readByte} : 32'h0000_0000;
        end
    end

    // ====================
    // output port and pin-route control
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            outBitQ         <= `GLUE_RST_GENERAL_OUTPUT; // [R2]
            transferEndSelQ <= `GLUE_RST_TRANSFER_END_SEL; // [R3]
        end
        else if (clkEn && wrLow)
        begin
            // only the documented bit is kept; other bits are dropped
            if (regIndex == `GLUE_IDX_OUTPUT_PORT_CTRL)
                outBitQ <= wrByte[`GLUE_BIT_GENERAL_OUTPUT]; // [R2] [R14]
            if (regIndex == `GLUE_IDX_PIN_ROUTE_CTRL)
                transferEndSelQ <= wrByte[`GLUE_BIT_TRANSFER_END_SEL]; // [R3] [R16]
        end
    end

    // ====================
    // generator 0 configuration
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            gen0StageOneQ <= `GLUE_RST_STAGE_ONE;
            gen0SecondQ   <= `GLUE_RST_SECOND_STAGE;
            gen0FinalQ    <= `GLUE_RST_FINAL_DIVIDER;
        end
        else if (clkEn && wrLow && regIndex == `GLUE_IDX_FREQ_GEN0_AND_INPUT_ONE)
        begin
            gen0StageOneQ <= wrByte[`GLUE_BIT_STAGE_ONE]; // [R5]
            gen0SecondQ   <= wrByte[`GLUE_BIT_SECOND_STAGE]; // [R6]
            gen0FinalQ    <= wrByte[`GLUE_LSB_FINAL_DIVIDER +: 3]; // [R7]
        end
    end

    // ====================
    // generator 1 configuration
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            gen1StageOneQ <= `GLUE_RST_STAGE_ONE;
            gen1SecondQ   <= `GLUE_RST_SECOND_STAGE;
            gen1FinalQ    <= `GLUE_RST_FINAL_DIVIDER;
        end
        else if (clkEn && wrLow && regIndex == `GLUE_IDX_FREQ_GEN1_AND_INPUT_TWO)
        begin
            gen1StageOneQ <= wrByte[`GLUE_BIT_STAGE_ONE]; // [R9]
            gen1SecondQ   <= wrByte[`GLUE_BIT_SECOND_STAGE]; // [R9]
            gen1FinalQ    <= wrByte[`GLUE_LSB_FINAL_DIVIDER +: 3]; // [R10]
        end
    end

    // ====================
    // edge interrupt enable and receive-pin select
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            edgeIntEnableQ  <= `GLUE_RST_EDGE_INT_ENABLE; // [R11]
            receiveFuncSelQ <= `GLUE_RST_RECEIVE_FUNC_SEL;
        end
        else if (clkEn && wrLow)
        begin
            if (regIndex == `GLUE_IDX_EDGE_INTERRUPT_CTRL)
                edgeIntEnableQ <= wrByte[`GLUE_BIT_EDGE_INT_ENABLE]; // [R11]
            if (regIndex == `GLUE_IDX_RECEIVE_PIN_SELECT)
                receiveFuncSelQ <= wrByte[`GLUE_BIT_RECEIVE_FUNC_SEL]; // [R13]
        end
    end

    // ====================
    // level status: a high pin wins over the clearing read
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            edgeStatusQ <= `GLUE_RST_EDGE_STATUS; // [R12]
        else if (clkEn)
        begin
            if (edgeInSync)
                edgeStatusQ <= 1'b1; // [R12]
            else if (rdEdgeCtrl)
                edgeStatusQ <= 1'b0; // [R12]
        end
    end

    // ====================
    // rising edge detect on the synchronised pin
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            edgeInPrevQ <= 1'b0;
        else if (clkEn)
            edgeInPrevQ <= edgeInSync;
    end

    assign risingEdge = edgeInSync && !edgeInPrevQ; // [R19]

    // ====================
    // pending request; a new edge beats an acknowledge in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            edgePendingQ <= 1'b0;
        else if (clkEn)
        begin
            if (risingEdge && edgeIntEnableQ)
                edgePendingQ <= 1'b1; // [R11]
            else if (edgeIntAck || !edgeIntEnableQ)
                edgePendingQ <= 1'b0;
        end
    end

    // global flag masks the request but does not lose it
    assign edgeIntReq = edgePendingQ && globalMaskableIntEnable; // [R18]
    // lowest-priority source; the core arbitrates against the others
    assign edgeIntVectorLow = `GLUE_EDGE_VECTOR; // [R17]

    // ====================
    // the two frequency generators
    freq_gen_divider u_gen0 (
        .clk_sys          (clk_sys),
        .rst_n            (rst_n),
        .clkEn            (clkEn),
        .stageOneSel      (gen0StageOneQ),
        .secondStageSel   (gen0SecondQ),
        .finalDividerCode (gen0FinalQ),
        .freqOut          (gen0Out)
    );

    freq_gen_divider u_gen1 (
        .clk_sys          (clk_sys),
        .rst_n            (rst_n),
        .clkEn            (clkEn),
        .stageOneSel      (gen1StageOneQ),
        .secondStageSel   (gen1SecondQ),
        .finalDividerCode (gen1FinalQ),
        .freqOut          (gen1Out)
    );

    // ====================
    // shared pins, registered so they never glitch on a mux change
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sharedPinQ <= 1'b0;
            serialRxQ  <= 1'b1;
        end
        else if (clkEn)
        begin
            sharedPinQ <= transferEndSelQ ? dmaDoneStrobeN : gen1Out; // [R3]
            // serial unit sees an idle-high line while the pin is input two
            serialRxQ  <= receiveFuncSelQ ? 1'b1 : inTwoSync; // [R13]
        end
    end

    assign generalOutputBit    = outBitQ; // [R2]
    assign freqOrDoneSharedPin = sharedPinQ;
    assign freqGenZeroOut      = gen0Out;
    assign serialReceiveData   = serialRxQ;
endmodule
`default_nettype wire

// [glue_io_and_freq_gen_props.sv]
`timescale 1ns/1ps
`default_nettype none

// ====================
// pin and bus checks
module glue_io_props
#(
    parameter int ADR_WIDTH = 8
)
(
    input wire logic                    clk_sys,
    input wire logic                    rst_n,
    input wire logic                    clkEn,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [ADR_WIDTH-1:0]    wb_adr_i,
    input wire logic [3:0]              wb_sel_i,
    input wire logic [31:0]             wb_dat_i,
    input wire logic                    wb_ack_o,
    input wire logic                    generalOutputBit,
    input wire logic                    freqOrDoneSharedPin,
    input wire logic                    freqGenZeroOut,
    input wire logic                    edgeInterruptInput,
    input wire logic                    dmaDoneStrobeN,
    input wire logic                    serialReceiveData,
    input wire logic                    globalMaskableIntEnable,
    input wire logic                    edgeIntAck,
    input wire logic                    edgeIntReq,
    input wire glue_io_pkg::vector_low_t edgeIntVectorLow
);
    import glue_io_pkg::*;
    logic       outExp_q, routeExp_q, enExp_q, rxSelExp_q, take;
    logic [2:0] fd0Exp_q, fd1Exp_q;

    // only aligned, mapped, low-lane writes reach the fields
    assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && clkEn && wb_sel_i[0]
                  && wb_adr_i[1:0] == 2'b00 && wb_adr_i[ADR_WIDTH-1:5] == '0;

    // shadow of the fields that drive the pins
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            outExp_q   <= 1'b1;
            routeExp_q <= 1'b0;
            enExp_q    <= 1'b0;
            rxSelExp_q <= 1'b0;
            fd0Exp_q   <= 3'h7;
            fd1Exp_q   <= 3'h7;
        end
        else if (take)
        begin
            case (wb_adr_i[4:2])
                3'h0: outExp_q <= wb_dat_i[4];
                3'h1: routeExp_q <= wb_dat_i[4];
                3'h2: fd0Exp_q <= wb_dat_i[2:0];
                3'h3: fd1Exp_q <= wb_dat_i[2:0];
                3'h4: enExp_q <= wb_dat_i[3];
                3'h5: rxSelExp_q <= wb_dat_i[2];
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    out_follow_a: assert property (wb_ack_o |=> generalOutputBit == outExp_q)
        else $error("output pin wrong");
    route_pin_a: assert property (routeExp_q && $past(routeExp_q)
        |-> freqOrDoneSharedPin == $past(dmaDoneStrobeN))
        else $error("done strobe not routed");
    gen_off_a: assert property (fd0Exp_q == 3'h7 && $past(fd0Exp_q) == 3'h7
        && $past(fd0Exp_q, 2) == 3'h7 |-> !freqGenZeroOut)
        else $error("generator 0 runs while switched off");
    gen1_off_a: assert property (!routeExp_q && !$past(routeExp_q, 3) && fd1Exp_q == 3'h7
        && $past(fd1Exp_q, 3) == 3'h7 && $stable(fd1Exp_q) |-> ##1 !freqOrDoneSharedPin)
        else $error("generator 1 runs while switched off");
    rx_const_a: assert property (rxSelExp_q[*3] |-> serialReceiveData)
        else $error("serial receive not idle");
    edge_req_a: assert property ($rose(edgeInterruptInput) && enExp_q
        ##1 (enExp_q && globalMaskableIntEnable && !edgeIntAck)[*4] |-> edgeIntReq)
        else $error("rising edge raised no request");
    no_req_a: assert property (!enExp_q && !edgeIntReq && globalMaskableIntEnable
        ##1 !enExp_q |-> !edgeIntReq)
        else $error("request raised while disabled");
    req_gate_a: assert property (edgeIntReq |-> globalMaskableIntEnable)
        else $error("request passes the global mask");
    vector_a: assert property (edgeIntVectorLow == 5'h0E)
        else $error("wrong low vector code");

    cover property ($rose(edgeIntReq));
    cover property (routeExp_q && !dmaDoneStrobeN);
    cover property (take && wb_adr_i[4:2] == 3'h2);
endmodule

bind glue_io_and_freq_gen glue_io_props #(.ADR_WIDTH(ADR_WIDTH)) props (.*);

`default_nettype wire

// [glue_io_consts.svh]
// How it works
// R1 - two independent generators divide the system clock by 320 up to 245760
// R2 - output pin follows the output bit at offset zero; reset sets it to 1
// R3 - pin-route bit at offset one picks done strobe (1) or generator 1 (0)
// R4 - read of offset two returns first input pin level in the stage-one bit
// R5 - written stage-one bit at offset two makes generator 0 divide by 10 or 30
// R6 - second-stage select makes generator 0 second stage divide by 16 or 64
// R7 - generator 0 final code 000..110 divides by 2..128; code 111 is off
// R8 - read of offset three returns second input pin level in the stage-one bit; code returns 0 there while select bit at offset five is 0
// R9 - offset three configures generator 1: first stage 10/30, second 16/64
// R10 - generator 1 final code 000..110 divides by 2..128; code 111 is off
// R11 - with enable bit at offset four set, rising edge on edge input raises request
// R12 - status bit sets while edge input high, clears on offset-four read while low
// R13 - select bit at offset five routes shared pin to serial receive or input two
// R14 - undefined bits read as unspecified and writes to them are ignored
// R15 - software writes the fixed 0 and 1 values shown in each layout
// R16 - software writes 10h to offset one to enable the done strobe on the pin
// R17 - edge interrupt is lowest priority vectored source with fixed low five bits
// R18 - edge interrupt is suppressed while the global maskable enable flag is 0
// R19 - every input pin passes a two-flop synchroniser before any use
// R20 - each generator gives a square wave and holds still while switched off
`ifndef GLUE_IO_CONSTS_SVH
`define GLUE_IO_CONSTS_SVH

// ====================
// register indices (byte address is four times the index)
`define GLUE_IDX_OUTPUT_PORT_CTRL         3'h0
`define GLUE_IDX_PIN_ROUTE_CTRL           3'h1
`define GLUE_IDX_FREQ_GEN0_AND_INPUT_ONE  3'h2
`define GLUE_IDX_FREQ_GEN1_AND_INPUT_TWO  3'h3
`define GLUE_IDX_EDGE_INTERRUPT_CTRL      3'h4
`define GLUE_IDX_RECEIVE_PIN_SELECT       3'h5

// ====================
// field positions
`define GLUE_BIT_GENERAL_OUTPUT   4
`define GLUE_BIT_TRANSFER_END_SEL 4
`define GLUE_BIT_STAGE_ONE        6
`define GLUE_BIT_SECOND_STAGE     3
`define GLUE_LSB_FINAL_DIVIDER    0
`define GLUE_BIT_EDGE_INT_ENABLE  3
`define GLUE_BIT_EDGE_STATUS      2
`define GLUE_BIT_RECEIVE_FUNC_SEL 2

// ====================
// reset values
`define GLUE_RST_GENERAL_OUTPUT   1'b1
`define GLUE_RST_TRANSFER_END_SEL 1'b0
`define GLUE_RST_STAGE_ONE        1'b0
`define GLUE_RST_SECOND_STAGE     1'b0
`define GLUE_RST_FINAL_DIVIDER    3'h7
`define GLUE_RST_EDGE_INT_ENABLE  1'b0
`define GLUE_RST_EDGE_STATUS      1'b0
`define GLUE_RST_RECEIVE_FUNC_SEL 1'b0

// ====================
// divider counts and fixed codes
`define GLUE_STAGE1_LOW   12'h000A
`define GLUE_STAGE1_HIGH  12'h001E
`define GLUE_STAGE2_LOW   12'h0010
`define GLUE_STAGE2_HIGH  12'h0040
`define GLUE_FINAL_OFF    3'h7
`define GLUE_EDGE_VECTOR  5'h0E

`endif

// [glue_io_pkg.sv]
package glue_io_pkg;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [2:0]  final_code_t;
    typedef logic [2:0]  reg_index_t;
    typedef logic [4:0]  vector_low_t;
endpackage

// [glue_pin_switches.sv]
`timescale 1ns/1ps
`default_nettype none

// ====================
// switches on the three input pins
module glue_pin_switches
(
    input  wire logic       clk_sys,
    input  wire logic [2:0] want,
    output logic            pinOne = 1'b0,
    output logic            pinTwo = 1'b0,
    output logic            pinEdge = 1'b0
);
    // switches move on the rising edge, like every bench input
    always @(posedge clk_sys)
    begin
        pinOne  <= want[0];
        pinTwo  <= want[1];
        pinEdge <= want[2];
    end
endmodule

`default_nettype wire

// [test_glue_io_and_freq_gen.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
        end \
    end

module test_glue_io_and_freq_gen;
    import glue_io_pkg::*;
    logic        clk_sys = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        doneN = 1'b1, gEn = 1'b0, intAck = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] datW = 32'h0000_0000, datR;
    logic [2:0]  want = 3'h0;
    logic        ack, outBit, sharedPin, gen0, rxData, intReq, pinOne, pinTwo, pinEdge;
    vector_low_t vecLow;
    reg_byte_t   rd;
    int          err_count = 0, checks_done = 0, n;

    // ====================
    // clock, parts
    always #5 clk_sys = ~clk_sys;

    glue_io_and_freq_gen #(.ADR_WIDTH(8)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
        .wb_ack_o(ack), .generalOutputBit(outBit), .freqOrDoneSharedPin(sharedPin),
        .freqGenZeroOut(gen0), .generalInputOne(pinOne), .receiveOrInputTwoPin(pinTwo),
        .edgeInterruptInput(pinEdge), .dmaDoneStrobeN(doneN), .serialReceiveData(rxData),
        .globalMaskableIntEnable(gEn), .edgeIntAck(intAck), .edgeIntReq(intReq),
        .edgeIntVectorLow(vecLow));

    glue_pin_switches sw (.clk_sys(clk_sys), .want(want), .pinOne(pinOne),
        .pinTwo(pinTwo), .pinEdge(pinEdge));

    // ====================
    // shared tasks
    task automatic test_done;
        $display("err_count=%0d checks_done=%0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    // classic cycle, held until ack is sampled high
    task automatic wbXfer(input logic w, input reg_index_t idx, input reg_byte_t wd);
        int k;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {3'h0, idx, 2'h0};
        datW <= {24'h00_0000, wd};
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (ack !== 1'b1);
        `CHK(k, 2);
        rd = datR[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rdChk(input reg_index_t idx, input reg_byte_t exp);
        wbXfer(1'b0, idx, 8'h00);
        `CHK(rd, exp);
    endtask

    // cycles until the chosen generator pin shows lvl
    task automatic waitLvl(input logic g, input logic lvl, output int k);
        k = 0;
        while ((g ? sharedPin : gen0) !== lvl && k < 30000)
        begin
            @(posedge clk_sys);
            k++;
        end
    endtask

    // switching off first restarts the count cleanly
    task automatic t_gen(input logic g, input reg_byte_t cfg, input int half);
        wbXfer(1'b1, {2'b01, g}, cfg | 8'h07);
        wbXfer(1'b1, {2'b01, g}, cfg);
        waitLvl(g, 1'b0, n);
        waitLvl(g, 1'b1, n);
        waitLvl(g, 1'b0, n);
        `CHK(n, half);
        $display("generator %0d cfg %h done", g, cfg);
    endtask

    // ====================
    // scenarios
    task automatic t_regs;
        rdChk(3'h0, 8'h10);
        rdChk(3'h1, 8'h00);
        rdChk(3'h2, 8'h07);
        rdChk(3'h3, 8'h07);
        rdChk(3'h4, 8'h00);
        rdChk(3'h5, 8'h00);
        rdChk(3'h6, 8'h00);
        wbXfer(1'b1, 3'h0, 8'h00);
        tick(2);
        `CHK(outBit, 1'b0);
        wbXfer(1'b1, 3'h0, 8'h90);
        tick(2);
        `CHK(outBit, 1'b1);
        rdChk(3'h0, 8'h10);
        $display("register test done");
    endtask

    task automatic t_route;
        wbXfer(1'b1, 3'h1, 8'h10);
        tick(2);
        doneN <= 1'b0;
        tick(2);
        `CHK(sharedPin, 1'b0);
        doneN <= 1'b1;
        tick(2);
        `CHK(sharedPin, 1'b1);
        wbXfer(1'b1, 3'h1, 8'h00);
        tick(3);
        `CHK(sharedPin, 1'b0);
        $display("route test done");
    endtask

    task automatic t_inputs;
        `CHK(rxData, 1'b0);
        want <= 3'b011;
        tick(4);
        rdChk(3'h2, 8'h47);
        rdChk(3'h3, 8'h07);
        `CHK(rxData, 1'b1);
        wbXfer(1'b1, 3'h5, 8'h04);
        rdChk(3'h3, 8'h47);
        want <= 3'b000;
        tick(4);
        `CHK(rxData, 1'b1);
        rdChk(3'h3, 8'h07);
        $display("input test done");
    endtask

    task automatic t_edge;
        gEn <= 1'b1;
        wbXfer(1'b1, 3'h4, 8'h08);
        want <= 3'b100;
        tick(6);
        `CHK(intReq, 1'b1);
        `CHK(vecLow, 5'h0E);
        gEn <= 1'b0;
        tick(1);
        `CHK(intReq, 1'b0);
        gEn <= 1'b1;
        tick(1);
        `CHK(intReq, 1'b1);
        intAck <= 1'b1;
        tick(1);
        intAck <= 1'b0;
        tick(1);
        `CHK(intReq, 1'b0);
        rdChk(3'h4, 8'h0C);
        want <= 3'b000;
        tick(4);
        rdChk(3'h4, 8'h0C);
        rdChk(3'h4, 8'h08);
        wbXfer(1'b1, 3'h4, 8'h00);
        want <= 3'b100;
        tick(6);
        `CHK(intReq, 1'b0);
        rdChk(3'h4, 8'h04);
        $display("edge test done");
    endtask

    task automatic t_off;
        wbXfer(1'b1, 3'h2, 8'h07);
        wbXfer(1'b1, 3'h3, 8'h07);
        tick(3);
        n = 0;
        repeat (700)
        begin
            @(posedge clk_sys);
            n += int'(gen0 !== 1'b0) + int'(sharedPin !== 1'b0);
        end
        `CHK(n, 0);
        $display("off test done");
    endtask

    // ====================
    // main sequence and watchdog
    initial
    begin
        tick(12);
        rst_n <= 1'b1;
        t_regs;
        t_route;
        for (int c = 0; c < 7; c++)
            t_gen(1'b0, {5'h00, c[2:0]}, 10 * 16 * (2 << c) / 2);
        t_gen(1'b0, 8'h48, 30 * 64 * 2 / 2);
        t_gen(1'b1, 8'h48, 30 * 64 * 2 / 2);
        t_gen(1'b1, 8'h01, 10 * 16 * 4 / 2);
        t_off;
        t_inputs;
        t_edge;
        test_done;
    end

    initial
    begin
        #1_000_000;
        err_count++;
        test_done;
    end
endmodule

`default_nettype wire
